//--- eeprom_pkg.sv
// shared constants, carriers and states of the two-wire eeprom target
`default_nettype none
package eeprom_pkg;
	localparam int MEM_BYTES = 256;
	localparam int ADDR_W = 8;
	localparam int PAGE_BYTES = 8;
	localparam int COL_W = 3;
	localparam int BYTE_W = 8;
	localparam int LAST_BIT = 7;
	// device address word layout
	localparam int RW_POS = 0;
	localparam int STRAP_LSB = 1;
	localparam int STRAP_MSB = 3;
	localparam int TYPE_LSB = 4;
	localparam int TYPE_MSB = 7;
	// self-timed write cycle, longest time rounds down
	localparam int CLK_HZ = 40_000_000;
	localparam int WR_CYCLE_MS = 5;
	localparam int WR_CYCLES_DEF = WR_CYCLE_MS * (CLK_HZ / 1000);
	localparam int BUF_DEPTH = 2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] data;
	} wbyte_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic [2:0] strap;
		logic wp;
	} pins_t;

	typedef enum {
		ST_IDLE,
		ST_DEV,
		ST_ACK_DEV,
		ST_WORD,
		ST_ACK_WORD,
		ST_WDATA,
		ST_ACK_DATA,
		ST_RDATA,
		ST_RACK
	} phase_t;
endpackage
`default_nettype wire

//--- pin_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_bad_w
		$error("pin_sync width must be at least 1");
	end

	// meta_r feeds q_o only
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o <= '0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- two_entry_buffer.sv
// small valid/ready fifo between byte receiver and page latch
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] slot_r [DEPTH];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] rd_r;
	logic [PW:0] cnt_r;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("buffer depth must be a power of two, at least 2");
	end

	assign in_ready_o = cnt_r != FULL_CNT;
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = slot_r[rd_r];

	always_ff @(posedge clk_i) begin
		if (push) begin
			slot_r[wr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_r + PW'(push);
			rd_r <= rd_r + PW'(pop);
			cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

//--- eeprom_target.sv
// two-wire eeprom target: bus framing, address counter, page latch, array
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - after each start, an 8-bit device address must match before anything else.
// - upper four address bits must equal the fixed device-type code.
// - address bits 3..1 must equal the three strap pins.
// - address bit 0 high means read, low means write.
// - on match drive acknowledge low; otherwise drop to standby and ignore.
// - write sends a word address after the device address, acknowledged low.
// - write-inhibit pin high at the stop blocks the array write.
// - data byte acknowledged; the stop starts the self-timed write cycle.
// - during the write cycle the bus is ignored entirely.
// - page write: more bytes without stop, each acknowledged, ended by stop.
// - per write byte only the three low address bits increment.
// - over eight bytes wrap within the page and overwrite earlier ones.
// - acknowledge polling answers only once the write cycle is over.
// - address counter holds last accessed address plus one, kept between transfers.
// - read addressing wraps from the last byte to the first byte.
// - current-address read shifts out the byte at the counter after acknowledge.
// - controller acknowledge on a read byte advances and sends the next byte.
// - eight-bit words, acknowledge driven low on the ninth clock.
// - write cycle lasts no longer than 5 ms after the stop.
// - stop, power-up and end of programming all return to standby.
module eeprom_target
	import eeprom_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary value
	parameter int WR_CYCLES = WR_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic addr_strap_pin_hi_i,
	input wire logic addr_strap_pin_mid_i,
	input wire logic addr_strap_pin_lo_i,
	input wire logic write_inhibit_pin_i,
	output logic write_busy_o
);
	localparam int CW = $clog2(WR_CYCLES + 1);
	localparam logic [CW-1:0] WR_LOAD = CW'(WR_CYCLES - 1);
	localparam logic [COL_W-1:0] LAST_COL = COL_W'(LAST_BIT);

	if (WR_CYCLES < 1) begin : g_bad_wr
		$error("write cycle count must be at least one");
	end

	pins_t raw;
	pins_t pins_s;
	pins_t prev_r;
	logic [BYTE_W-1:0] mem_r [MEM_BYTES];
	logic [BYTE_W-1:0] page_data_r [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] page_mask_r;
	logic [ADDR_W-1:COL_W] page_row_r;

	phase_t st_r, st_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic full_r, full_nxt;
	logic mack_r, mack_nxt;
	logic rw_r, rw_nxt;
	logic oe_r, oe_nxt;
	logic [BYTE_W-1:0] shift_r, shift_nxt;
	logic [BYTE_W-1:0] tx_r, tx_nxt;
	logic [BYTE_W-1:0] devaddr_r, devaddr_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic busy_r;
	logic [CW-1:0] wr_cnt_r;
	logic push;
	logic load_rd;
	logic start_wr;

	wbyte_t push_data;
	wbyte_t drain_data;
	logic push_ready;
	logic drain_valid;

	assign raw = '{scl: scl_i, sda: sda_i,
		strap: {addr_strap_pin_hi_i, addr_strap_pin_mid_i, addr_strap_pin_lo_i},
		wp: write_inhibit_pin_i};

	pin_sync #(
		.W($bits(pins_t))
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(raw),
		.q_o(pins_s)
	);

	// bus events from the synchronised levels
	wire scl_rise = pins_s.scl && !prev_r.scl;
	wire scl_fall = !pins_s.scl && prev_r.scl;
	wire start_ev = pins_s.scl && prev_r.scl && prev_r.sda && !pins_s.sda;
	wire stop_ev = pins_s.scl && prev_r.scl && !prev_r.sda && pins_s.sda;
	wire [BYTE_W-1:0] shift_in = {shift_r[BYTE_W-2:0], pins_s.sda};
	wire [BYTE_W-1:0] rd_byte = mem_r[addr_r];
	wire commit = busy_r && wr_cnt_r == '0;
	wire dev_match = shift_r[TYPE_MSB:TYPE_LSB] == DEV_TYPE &&
		shift_r[STRAP_MSB:STRAP_LSB] == pins_s.strap;
	wire [ADDR_W-1:0] page_next = {addr_r[ADDR_W-1:COL_W], addr_r[COL_W-1:0] + 3'h1};

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		full_nxt = full_r;
		mack_nxt = mack_r;
		rw_nxt = rw_r;
		oe_nxt = oe_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		devaddr_nxt = devaddr_r;
		addr_nxt = addr_r;
		push = 1'b0;
		load_rd = 1'b0;
		start_wr = 1'b0;
		if (busy_r) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end else if (start_ev) begin
			st_nxt = ST_DEV;
			cnt_nxt = '0;
			full_nxt = 1'b0;
			oe_nxt = 1'b0;
		end else if (stop_ev) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
			start_wr = page_mask_r != '0 && !pins_s.wp;
		end else begin
			case (st_r)
				ST_DEV, ST_WORD, ST_WDATA: begin
					if (scl_rise) begin
						shift_nxt = shift_in;
						cnt_nxt = cnt_r + 3'h1;
						full_nxt = cnt_r == LAST_COL;
					end else if (scl_fall && full_r) begin
						full_nxt = 1'b0;
						if (st_r == ST_DEV) begin
							if (dev_match) begin
								st_nxt = ST_ACK_DEV;
								oe_nxt = 1'b1;
								rw_nxt = shift_r[RW_POS];
								devaddr_nxt = shift_r;
							end else begin
								st_nxt = ST_IDLE;
							end
						end else if (st_r == ST_WORD) begin
							st_nxt = ST_ACK_WORD;
							oe_nxt = 1'b1;
							addr_nxt = shift_r;
						end else if (push_ready) begin
							push = 1'b1;
							addr_nxt = page_next;
							st_nxt = ST_ACK_DATA;
							oe_nxt = 1'b1;
						end else begin
							// no room: byte refused with no acknowledge
							st_nxt = ST_IDLE;
						end
					end
				end
				ST_ACK_DEV: begin
					if (scl_fall) begin
						cnt_nxt = '0;
						if (rw_r) begin
							load_rd = 1'b1;
							st_nxt = ST_RDATA;
						end else begin
							oe_nxt = 1'b0;
							st_nxt = ST_WORD;
						end
					end
				end
				ST_ACK_WORD, ST_ACK_DATA: begin
					if (scl_fall) begin
						oe_nxt = 1'b0;
						cnt_nxt = '0;
						st_nxt = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						cnt_nxt = cnt_r + 3'h1;
						full_nxt = cnt_r == LAST_COL;
					end else if (scl_fall) begin
						if (full_r) begin
							full_nxt = 1'b0;
							oe_nxt = 1'b0;
							mack_nxt = 1'b0;
							st_nxt = ST_RACK;
						end else begin
							tx_nxt = {tx_r[BYTE_W-2:0], 1'b0};
							oe_nxt = !tx_r[BYTE_W-2];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						if (pins_s.sda) begin
							st_nxt = ST_IDLE;
						end else begin
							mack_nxt = 1'b1;
						end
					end else if (scl_fall && mack_r) begin
						load_rd = 1'b1;
						cnt_nxt = '0;
						st_nxt = ST_RDATA;
					end
				end
				default: begin
					st_nxt = ST_IDLE;
				end
			endcase
		end
		if (load_rd) begin
			tx_nxt = rd_byte;
			oe_nxt = !rd_byte[BYTE_W-1];
			// counter is last read plus one
			addr_nxt = addr_r + 8'h01;
		end
	end

	assign push_data = '{addr: addr_r, data: shift_r};

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_r <= '0;
			st_r <= ST_IDLE;
			cnt_r <= '0;
			full_r <= 1'b0;
			mack_r <= 1'b0;
			rw_r <= 1'b0;
			oe_r <= 1'b0;
			shift_r <= '0;
			tx_r <= '0;
			devaddr_r <= '0;
			addr_r <= '0;
		end else begin
			prev_r <= pins_s;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			full_r <= full_nxt;
			mack_r <= mack_nxt;
			rw_r <= rw_nxt;
			oe_r <= oe_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			devaddr_r <= devaddr_nxt;
			addr_r <= addr_nxt;
		end
	end

	// the page latch never stalls except while programming
	two_entry_buffer #(
		.WIDTH($bits(wbyte_t)),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push),
		.in_ready_o(push_ready),
		.in_data_i(push_data),
		.out_valid_o(drain_valid),
		.out_ready_i(!busy_r),
		.out_data_o(drain_data)
	);

	wire drain = drain_valid && !busy_r;
	wire discard = stop_ev && !busy_r && pins_s.wp;

	// later bytes overwrite the same page slot
	always_ff @(posedge clk_i) begin
		if (drain) begin
			page_data_r[drain_data.addr[COL_W-1:0]] <= drain_data.data;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			page_mask_r <= '0;
			page_row_r <= '0;
		end else if (commit || discard) begin
			page_mask_r <= '0;
		end else if (drain) begin
			page_mask_r[drain_data.addr[COL_W-1:0]] <= 1'b1;
			page_row_r <= drain_data.addr[ADDR_W-1:COL_W];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			wr_cnt_r <= '0;
		end else if (start_wr) begin
			busy_r <= 1'b1;
			wr_cnt_r <= WR_LOAD;
		end else if (commit) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			wr_cnt_r <= wr_cnt_r - 1'b1;
		end
	end

	// array has no reset: contents survive a bus reset
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < PAGE_BYTES; i++) begin
			if (commit && page_mask_r[i]) begin
				mem_r[{page_row_r, COL_W'(i)}] <= page_data_r[i];
			end
		end
	end

	// open drain: the pin is only ever pulled low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
			write_busy_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			sda_oe_o <= oe_nxt;
			write_busy_o <= start_wr || (busy_r && !commit);
		end
	end

	property p_quiet_busy;
		@(posedge clk_i) disable iff (rst_i)
		busy_r |=> !sda_oe_o;
	endproperty
	a_quiet_busy: assert property (p_quiet_busy)
		else $error("target drove the bus while programming");

	property p_match_fields;
		@(posedge clk_i) disable iff (rst_i)
		$rose(oe_r) && st_r == ST_ACK_DEV |->
			devaddr_r[TYPE_MSB:TYPE_LSB] == DEV_TYPE &&
			devaddr_r[STRAP_MSB:STRAP_LSB] == pins_s.strap;
	endproperty
	a_match_fields: assert property (p_match_fields)
		else $error("device address acknowledged without a match");

	property p_nomatch_idle;
		@(posedge clk_i) disable iff (rst_i)
		st_r == ST_DEV && scl_fall && full_r && !dev_match && !busy_r &&
			!start_ev && !stop_ev |=> st_r == ST_IDLE && !sda_oe_o;
	endproperty
	a_nomatch_idle: assert property (p_nomatch_idle)
		else $error("mismatched address did not return to standby");

	property p_word_ack;
		@(posedge clk_i) disable iff (rst_i)
		$rose(st_r == ST_ACK_WORD) |-> sda_oe_o && !sda_o;
	endproperty
	a_word_ack: assert property (p_word_ack)
		else $error("word address not acknowledged low");

	property p_page_wrap;
		@(posedge clk_i) disable iff (rst_i)
		push |=> addr_r[ADDR_W-1:COL_W] == $past(addr_r[ADDR_W-1:COL_W]) &&
			addr_r[COL_W-1:0] == $past(addr_r[COL_W-1:0]) + 3'h1;
	endproperty
	a_page_wrap: assert property (p_page_wrap)
		else $error("write address left its page");

	property p_read_advance;
		@(posedge clk_i) disable iff (rst_i)
		load_rd |=> addr_r == $past(addr_r) + 8'h01 && tx_r == $past(rd_byte);
	endproperty
	a_read_advance: assert property (p_read_advance)
		else $error("read counter did not advance by one");

	property p_inhibit;
		@(posedge clk_i) disable iff (rst_i)
		stop_ev && !busy_r && pins_s.wp |=> !busy_r && page_mask_r == '0;
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("inhibited write started a cycle");

	property p_stop_start;
		@(posedge clk_i) disable iff (rst_i)
		stop_ev && !busy_r && !pins_s.wp && page_mask_r != '0 |=>
			busy_r && wr_cnt_r == WR_LOAD;
	endproperty
	a_stop_start: assert property (p_stop_start)
		else $error("stop after data did not start programming");

	property p_wr_bound;
		@(posedge clk_i) disable iff (rst_i)
		busy_r |=> (busy_r && wr_cnt_r == $past(wr_cnt_r) - 1'b1) ||
			(!busy_r && $past(wr_cnt_r) == '0);
	endproperty
	a_wr_bound: assert property (p_wr_bound)
		else $error("write cycle timer did not run down once per clock");

	property p_drive_after_fall;
		@(posedge clk_i) disable iff (rst_i)
		$rose(oe_r) |-> $past(scl_fall);
	endproperty
	a_drive_after_fall: assert property (p_drive_after_fall)
		else $error("data line driven other than after a clock fall");

	property p_stop_standby;
		@(posedge clk_i) disable iff (rst_i)
		stop_ev |=> st_r == ST_IDLE ##1 !sda_oe_o;
	endproperty
	a_stop_standby: assert property (p_stop_standby)
		else $error("stop did not return to standby");
endmodule
`default_nettype wire

//--- bus_ctl.sv
// two-wire bus controller model that drives clock and data toward the target
`timescale 1ns/1ps
`default_nettype none
module bus_ctl (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// bus idles released, clock parked high between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic start();
		sda_o = 1'b1;
		// wait past the target's ack release so this is not taken as a stop
		tick(5);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		// data moves one clock after the clock fall, never with it
		tick(1);
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b1;
		tick(4);
	endtask
	// one bit: 5 clocks low, 3 high, 200 ns; data moves only while clock low
	task automatic bit_cycle(input logic b, output logic s);
		tick(1);
		sda_o = b;
		tick(4);
		scl_o = 1'b1;
		tick(2);
		s = sda_i;
		tick(1);
		scl_o = 1'b0;
	endtask
	// eight bits msb first, then the target's acknowledge
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(b[i], s);
		end
		bit_cycle(1'b1, ack);
	endtask
	// low acknowledge asks for more, high ends the read
	task automatic rbyte(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, b[i]);
		end
		bit_cycle(!more, s);
	endtask
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the two-wire eeprom target
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [3:0] TYPE_CODE = 4'h5; // arbitrary value
	localparam int WR_N = 400;
	localparam logic [2:0] STRAP = 3'b101;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scl, ctl_sda, sda_w, sda_o, sda_oe, busy, wp;
	logic [2:0] strap;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	// pulled-up open-drain line
	assign sda_w = ctl_sda & ~(sda_oe & ~sda_o);
	bus_ctl ctl (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(ctl_sda));
	eeprom_target #(.DEV_TYPE(TYPE_CODE), .WR_CYCLES(WR_N)) dut (
		.clk_i(clk),
		.rst_i(rst),
		.scl_i(scl),
		.sda_i(sda_w),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe),
		.addr_strap_pin_hi_i(strap[2]),
		.addr_strap_pin_mid_i(strap[1]),
		.addr_strap_pin_lo_i(strap[0]),
		.write_inhibit_pin_i(wp),
		.write_busy_o(busy)
	);
	task automatic print_verdict();
		if (failures == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic ack_is(input logic ack, input logic exp);
		check("ack", {7'h0, ack}, {7'h0, exp});
	endtask
	function automatic logic [7:0] dev(input logic rd);
		return {TYPE_CODE, strap, rd};
	endfunction
	// wrong type code, then each strap bit wrong: never acknowledged
	task automatic wrong_addr();
		logic ack;
		logic [7:0] w;
		for (int k = 0; k < 4; k++) begin
			w = (k == 0) ? {4'h6, strap, 1'b0} : {TYPE_CODE, strap ^ (3'b001 << (k - 1)), 1'b0};
			ctl.start();
			ctl.wbyte(w, ack);
			ack_is(ack, 1'b1);
			ctl.wbyte(8'h10, ack);
			ack_is(ack, 1'b1);
			ctl.stop();
		end
	endtask
	task automatic do_write(input logic [7:0] a, input logic [7:0] d[$]);
		logic ack;
		int n;
		ctl.start();
		ctl.wbyte(dev(1'b0), ack);
		ack_is(ack, 1'b0);
		ctl.wbyte(a, ack);
		ack_is(ack, 1'b0);
		foreach (d[i]) begin
			ctl.wbyte(d[i], ack);
			ack_is(ack, 1'b0);
		end
		ctl.stop();
		repeat (6) @(negedge clk);
		check("busy", {7'h0, busy}, {7'h0, !wp});
		if (!wp) begin
			ctl.start();
			ctl.wbyte(dev(1'b1), ack);
			ack_is(ack, 1'b1);
			ctl.stop();
			n = 0;
			while (busy !== 1'b0 && n < WR_N) begin
				@(negedge clk);
				n++;
			end
			check("busy end", {7'h0, busy}, 8'h00);
			ctl.start();
			ctl.wbyte(dev(1'b0), ack);
			ack_is(ack, 1'b0);
			ctl.stop();
		end
	endtask
	task automatic do_read(input logic [7:0] a, input logic rnd, input logic [7:0] e[$]);
		logic ack;
		logic [7:0] b;
		ctl.start();
		if (rnd) begin
			ctl.wbyte(dev(1'b0), ack);
			ack_is(ack, 1'b0);
			ctl.wbyte(a, ack);
			ack_is(ack, 1'b0);
			ctl.start();
		end
		ctl.wbyte(dev(1'b1), ack);
		ack_is(ack, 1'b0);
		foreach (e[i]) begin
			ctl.rbyte(i < e.size() - 1, b);
			check("read byte", b, e[i]);
		end
		ctl.stop();
	endtask
	// straps moved: the new address answers, the old one is refused
	task automatic strap_move();
		logic ack;
		strap = 3'b010;
		repeat (4) @(negedge clk);
		ctl.start();
		ctl.wbyte({TYPE_CODE, STRAP, 1'b1}, ack);
		ack_is(ack, 1'b1);
		ctl.stop();
		do_read(8'h2a, 1'b1, '{8'h44});
		wrong_addr();
	endtask
	initial begin
		wp = 1'b0;
		strap = STRAP;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check("oe at reset", {7'h0, sda_oe}, 8'h00);
		check("busy at reset", {7'h0, busy}, 8'h00);
		wrong_addr();
		do_write(8'hff, '{8'ha5});
		do_write(8'h00, '{8'h5a});
		// read counter rolls from the top byte to the bottom
		do_read(8'hff, 1'b1, '{8'ha5, 8'h5a});
		// ten bytes from column 6: columns 6 and 7 are overwritten
		do_write(8'h2e, '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48,
			8'h49});
		do_read(8'h28, 1'b1, '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48});
		do_read(8'h00, 1'b0, '{8'h49});
		wp = 1'b1;
		do_write(8'h2a, '{8'h99});
		wp = 1'b0;
		do_read(8'h2a, 1'b1, '{8'h44});
		strap_move();
		print_verdict();
	end
endmodule
`default_nettype wire
